// ---- rtl/apc_defines.svh ----
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets within one converter's 16-byte block
// ----------------------------------------------------------------
`define APC_OFF_CTL0 8'h60
`define APC_OFF_CTL1 8'h61
`define APC_OFF_CTL2 8'h62
`define APC_OFF_CTL3 8'h63
`define APC_OFF_CTL4 8'h64
`define APC_OFF_CTL5 8'h65
`define APC_OFF_STAT 8'h66
`define APC_OFF_TEST 8'h67
`define APC_OFF_PORT 8'h6f
`define APC_BLOCK_BYTES 8'h10
`define APC_BLOCK_MASK 8'hf0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define APC_CTL2_PWR 7
`define APC_CTL2_AFFC 6
`define APC_CTL2_SWAI 5
`define APC_CTL2_IE 1
`define APC_CTL2_SEQF 0
`define APC_CTL3_FRZ_LO 0
`define APC_CTL3_FRZ_HI 1
`define APC_TEST_RST 0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define APC_CTL0_RST 8'h00
`define APC_CTL2_RST 8'h00
`define APC_CTL3_RST 8'h00
`define APC_CTL4_RST 8'h00
`define APC_CTL5_RST 8'h00
`define APC_TEST_RST_VAL 8'h00
`define APC_CONV_CYCLES 16'h0028
`define APC_NUM_CH 8

`endif

// ---- rtl/apc_pkg.sv ----
package apc_pkg;
   typedef enum logic [1:0] {
      APC_FRZ_IGNORE,
      APC_FRZ_FINISH,
      APC_FRZ_NOW,
      APC_FRZ_NOW_ALT
   } apc_frz_e;

   typedef enum logic [1:0] {
      APC_ST_IDLE,
      APC_ST_CONV,
      APC_ST_HOLD
   } apc_seq_e;
endpackage

// ---- rtl/apc_sync.sv ----
// two-flop synchroniser for a bus of pins
module apc_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // apc_sync

// ---- rtl/apc_ctrl.sv ----
// Contract
// - stop gates clocks, same as power-off
// - wait powers down only when enabled
// - registers unreachable during wait power-down
// - freeze field picks one of three responses
// - frozen state holds until freeze released
// - registers stay accessible while frozen
// - test reset keeps power-up bit
// - module reset ends sequence, clears flags
// - leaving wait resumes without reset
// - freeze never resets; finish leaves idle
// - power-up keeps register contents
// - start-register write restarts and clears flags
// - 8-bit input-only port on analog pins
// - port read leaves conversion untouched
// - each instance owns a 16-byte block
// - offset zero write aborts sequence
// - offset one ignores writes, special-mode reads
// - control two/three writes never abort; here a control two write that clears the power bit aborts
// - sequence flag read-only in control two
// - power bit 0 off, 1 on
// - power bit resets to zero
// - power-down aborts running sequence
`include "apc_defines.svh"

module apc_ctrl #(
   parameter logic [7:0] BASE = 8'h60,
   parameter logic [15:0] CONV_CYCLES = `APC_CONV_CYCLES,
   parameter int SEQ_LEN = `APC_NUM_CH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // processor mode inputs
   input wire logic stop_req,
   input wire logic wait_req,
   input wire logic debug_freeze_signal,
   input wire logic special_mode,
   // analog pins sampled digitally
   input wire logic [7:0] analog_pin_digital_port,
   // axi4-lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter status
   output logic powered,
   output logic converting,
   output logic frozen
);
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [7:0] port_s;
   logic [3:0] mode_s;

   apc_sync #(.WIDTH(8)) u_port_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(analog_pin_digital_port),
      .sync_out(port_s)
   );

   apc_sync #(.WIDTH(4)) u_mode_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in({special_mode, stop_req, wait_req, debug_freeze_signal}),
      .sync_out(mode_s)
   );

   logic special_s, stop_s, wait_s, frz_s;
   assign special_s = mode_s[3];
   assign stop_s = mode_s[2];
   assign wait_s = mode_s[1];
   assign frz_s = mode_s[0];

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] ctl0_q, ctl2_q, ctl3_q, ctl4_q, ctl5_q, test_q;
   logic seq_flag_q;
   logic [SEQ_LEN-1:0] ccf_q;
   logic [2:0] conv_idx_q;
   logic [15:0] conv_cnt_q;
   apc_pkg::apc_seq_e seq_q;

   logic mod_rst;
   logic wait_down, power_on;
   apc_pkg::apc_frz_e frz_sel;

   assign mod_rst = test_q[`APC_TEST_RST];
   assign wait_down = wait_s & ctl2_q[`APC_CTL2_SWAI];
   assign power_on = ctl2_q[`APC_CTL2_PWR] & ~stop_s & ~wait_down;
   assign frz_sel = apc_pkg::apc_frz_e'({ctl3_q[`APC_CTL3_FRZ_HI], ctl3_q[`APC_CTL3_FRZ_LO]});

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   logic aw_q, w_q, ar_q;
   logic [7:0] awaddr_q, araddr_q;
   logic aw_hi_q, ar_hi_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire, rd_fire;
   logic bus_blocked;

   // no register access in wait power-down
   assign bus_blocked = wait_down;
   assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_q & ~s_axi_bvalid;
   assign s_axi_arready = ~ar_q & ~s_axi_rvalid;
   assign wr_fire = aw_q & w_q & ~s_axi_bvalid;
   assign rd_fire = ar_q & ~s_axi_rvalid;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_q <= 1'b0;
         awaddr_q <= 8'h00;
         aw_hi_q <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_q <= 1'b1;
         awaddr_q <= s_axi_awaddr[7:0];
         aw_hi_q <= |s_axi_awaddr[31:8];
      end else if (wr_fire) begin
         aw_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ar_q <= 1'b0;
         araddr_q <= 8'h00;
         ar_hi_q <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         ar_q <= 1'b1;
         araddr_q <= s_axi_araddr[7:0];
         ar_hi_q <= |s_axi_araddr[31:8];
      end else if (rd_fire) begin
         ar_q <= 1'b0;
      end
   end

   // word index: each byte offset takes one aligned word (byte addr = 4 * offset)
   logic [7:0] wr_off, rd_off;
   logic wr_in_blk, rd_in_blk;
   assign wr_off = 8'(BASE + {2'b00, awaddr_q[7:2]});
   assign rd_off = 8'(BASE + {2'b00, araddr_q[7:2]});
   // high address bits are kept so far addresses cannot alias into the block
   assign wr_in_blk = !aw_hi_q && (awaddr_q[7:6] == 2'b00);
   assign rd_in_blk = !ar_hi_q && (araddr_q[7:6] == 2'b00);

   logic wr_ok, wr_en;
   logic wr_ctl0, wr_ctl2, wr_ctl3, wr_ctl4, wr_ctl5, wr_test;
   assign wr_ok = wr_in_blk & ~bus_blocked;
   assign wr_en = wr_fire & wr_ok & wstrb_q[0];
   assign wr_ctl0 = wr_en && wr_off == `APC_OFF_CTL0;
   assign wr_ctl2 = wr_en && wr_off == `APC_OFF_CTL2;
   assign wr_ctl3 = wr_en && wr_off == `APC_OFF_CTL3;
   assign wr_ctl4 = wr_en && wr_off == `APC_OFF_CTL4;
   assign wr_ctl5 = wr_en && wr_off == `APC_OFF_CTL5;
   assign wr_test = wr_en && wr_off == `APC_OFF_TEST;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic [7:0] rd_val;
   logic rd_ok;
   always_comb begin
      rd_val = 8'h00;
      rd_ok = rd_in_blk & ~bus_blocked;
      case (rd_off)
         `APC_OFF_CTL0: rd_val = ctl0_q;
         // reserved read in special mode only
         `APC_OFF_CTL1: begin
            rd_val = 8'h00;
            rd_ok = rd_ok & special_s;
         end
         // sequence flag shown, not stored from writes
         `APC_OFF_CTL2: rd_val = {ctl2_q[7:1], seq_flag_q};
         `APC_OFF_CTL3: rd_val = ctl3_q;
         `APC_OFF_CTL4: rd_val = ctl4_q;
         `APC_OFF_CTL5: rd_val = ctl5_q;
         `APC_OFF_STAT: rd_val = ccf_q;
         `APC_OFF_TEST: rd_val = test_q;
         // port read has no side effect
         `APC_OFF_PORT: rd_val = port_s;
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OK;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_ok ? {24'h000000, rd_val} : 32'h00000000;
         s_axi_rresp <= rd_ok ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // offset zero is plain storage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl0_q <= `APC_CTL0_RST;
      end else if (mod_rst) begin
         ctl0_q <= `APC_CTL0_RST;
      end else if (wr_ctl0) begin
         ctl0_q <= wdata_q[7:0];
      end
   end

   // power bit clears on system reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl2_q <= `APC_CTL2_RST;
      end else if (mod_rst) begin
         ctl2_q <= {ctl2_q[`APC_CTL2_PWR], 7'h00};
      end else if (wr_ctl2) begin
         ctl2_q <= {wdata_q[7:1], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl3_q <= `APC_CTL3_RST;
         ctl4_q <= `APC_CTL4_RST;
         ctl5_q <= `APC_CTL5_RST;
      end else if (mod_rst) begin
         ctl3_q <= `APC_CTL3_RST;
         ctl4_q <= `APC_CTL4_RST;
         ctl5_q <= `APC_CTL5_RST;
      end else begin
         if (wr_ctl3) begin
            ctl3_q <= wdata_q[7:0] & 8'h0f;
         end
         if (wr_ctl4) begin
            ctl4_q <= wdata_q[7:0];
         end
         if (wr_ctl5) begin
            ctl5_q <= wdata_q[7:0];
         end
      end
   end

   // test reset bit self-clears on the same edge as the module reset it causes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         test_q <= `APC_TEST_RST_VAL;
      end else if (mod_rst) begin
         test_q <= `APC_TEST_RST_VAL;
      end else if (wr_test) begin
         test_q <= wdata_q[7:0];
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   logic restart, abort, freeze_now, freeze_edge, conv_last, seq_last;
   assign restart = wr_ctl4 | wr_ctl5;
   assign abort = wr_ctl0 | ~power_on;
   assign freeze_now = frz_s &&
      (frz_sel == apc_pkg::APC_FRZ_NOW || frz_sel == apc_pkg::APC_FRZ_NOW_ALT);
   assign freeze_edge = frz_s && frz_sel == apc_pkg::APC_FRZ_FINISH;
   assign conv_last = conv_cnt_q == CONV_CYCLES - 16'h0001;
   assign seq_last = conv_idx_q == 3'(SEQ_LEN - 1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_q <= apc_pkg::APC_ST_IDLE;
         conv_cnt_q <= 16'h0000;
         conv_idx_q <= 3'h0;
      end else if (mod_rst) begin
         seq_q <= apc_pkg::APC_ST_IDLE;
         conv_cnt_q <= 16'h0000;
         conv_idx_q <= 3'h0;
      end else if (restart && power_on) begin
         seq_q <= apc_pkg::APC_ST_CONV;
         conv_cnt_q <= 16'h0000;
         conv_idx_q <= 3'h0;
      end else if (abort && !wait_down) begin
         seq_q <= apc_pkg::APC_ST_IDLE;
         conv_cnt_q <= 16'h0000;
         conv_idx_q <= 3'h0;
      end else if (wait_down) begin
         seq_q <= seq_q;
      end else begin
         case (seq_q)
            apc_pkg::APC_ST_IDLE: seq_q <= apc_pkg::APC_ST_IDLE;
            apc_pkg::APC_ST_CONV: begin
               if (!freeze_now) begin
                  conv_cnt_q <= conv_last ? 16'h0000 : conv_cnt_q + 16'h0001;
                  if (conv_last) begin
                     conv_idx_q <= seq_last ? 3'h0 : conv_idx_q + 3'h1;
                     if (seq_last || freeze_edge) begin
                        seq_q <= freeze_edge ? apc_pkg::APC_ST_HOLD : apc_pkg::APC_ST_IDLE;
                     end
                  end
               end
            end
            apc_pkg::APC_ST_HOLD: begin
               if (!frz_s) begin
                  seq_q <= apc_pkg::APC_ST_IDLE;
               end
            end
            default: seq_q <= apc_pkg::APC_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // completion flags: clear wins over set
   // ----------------------------------------------------------------
   logic conv_done;
   assign conv_done = seq_q == apc_pkg::APC_ST_CONV && conv_last && power_on
      && !wait_down && !freeze_now && !restart && !abort && !mod_rst;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ccf_q <= '0;
         seq_flag_q <= 1'b0;
      end else begin
         if (mod_rst || restart) begin
            ccf_q <= '0;
            seq_flag_q <= 1'b0;
         end else if (conv_done) begin
            ccf_q[conv_idx_q] <= 1'b1;
            seq_flag_q <= seq_flag_q | seq_last;
         end
      end
   end

   assign powered = power_on;
   assign converting = seq_q == apc_pkg::APC_ST_CONV;
   assign frozen = (seq_q == apc_pkg::APC_ST_HOLD) || (freeze_now && converting);
endmodule // apc_ctrl

// ---- tb/apc_ctrl_properties.sv ----
module apc_ctrl_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // mode inputs
   input wire logic stop_req,
   input wire logic wait_req,
   input wire logic debug_freeze_signal,
   input wire logic special_mode,
   // read channels
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // write response
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // status
   input wire logic powered,
   input wire logic converting,
   input wire logic frozen
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_stop_off;
      stop_req [*4] |-> !powered;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("stop left power on");
   property p_off_idle;
      // a wait power-down keeps its place, so it is left out here
      !powered && !$past(powered) && !wait_req && !$past(wait_req, 1)
         && !$past(wait_req, 2) && !$past(wait_req, 3) |-> !converting;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("converting while off");
   property p_frz_cause;
      frozen |-> ($past(debug_freeze_signal, 1) || $past(debug_freeze_signal, 2)
         || $past(debug_freeze_signal, 3));
   endproperty
   a_frz_cause: assert property (p_frz_cause) else $error("frozen without request");
   property p_thaw;
      !debug_freeze_signal [*4] |-> !frozen;
   endproperty
   a_thaw: assert property (p_thaw) else $error("freeze not released");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_rsv_rd;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h4 && !special_mode
         && !$past(special_mode, 1) && !$past(special_mode, 2)
         |-> ##[1:3] (s_axi_rvalid && s_axi_rresp == 2'b10);
   endproperty
   a_rsv_rd: assert property (p_rsv_rd) else $error("reserved read allowed");
   property p_outside;
      s_axi_arvalid && s_axi_arready && s_axi_araddr >= 32'h40
         |-> ##[1:3] (s_axi_rvalid && s_axi_rresp == 2'b10);
   endproperty
   a_outside: assert property (p_outside) else $error("outside block accepted");
   property p_byte;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_byte: assert property (p_byte) else $error("upper read bits set");
endmodule // apc_ctrl_checker

bind apc_ctrl apc_ctrl_checker u_chk (.*);

// ---- tb/apc_host_model.sv ----
// bus master standing in for host software
module apc_host_model (
   input wire logic clk,
   // write side
   output logic [31:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read side
   output logic [31:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 32'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_araddr = 32'h0;
   end
   // address and data go out together; each drops once taken
   task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
      bit aw;
      bit w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // one edge passes so a following call never re-raises ready in the same step
      @(posedge clk);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
endmodule // apc_host_model

// ---- tb/adc_power_freeze_reset_control_tb.sv ----
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("FAIL %0t got %h exp %h", $time, g, e); end end

module adc_power_freeze_reset_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] OK = 2'b00, SE = 2'b10;
   localparam logic [31:0] A0 = 32'h0, A1 = 32'h4, A2 = 32'h8, A3 = 32'hc, A4 = 32'h10;
   localparam logic [31:0] A5 = 32'h14, AS = 32'h18, AT = 32'h1c, AP = 32'h3c;
   logic clk = 1'b0;
   logic rst_b, stop_req, wait_req, debug_freeze_signal, special_mode;
   logic [7:0] analog_pin_digital_port;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic powered, converting, frozen;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   // short conversions keep the freeze waits brief
   apc_ctrl #(.CONV_CYCLES(16'h0010), .SEQ_LEN(8)) DUT (.*);
   apc_host_model u_host (.*);

   always #2 clk = ~clk;

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er = OK);
      logic [1:0] r;
      u_host.wr(a, d, r);
      `CHK(r, er)
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er = OK,
         input bit cv = 1'b1);
      logic [31:0] v;
      logic [1:0] r;
      u_host.rd(a, v, r);
      `CHK(r, er)
      if (cv && er == OK) `CHK(v, {24'h0, ed})
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      `CHK(powered, 1'b0)
      rd(A2, 8'h00);
      rd(A3, 8'h00);
      rd(32'h40, 8'h00, SE);
      rd(A1, 8'h00, SE);
      wr(A1, 8'h5a);
      special_mode <= 1'b1;
      // the mode pin passes a two-flop synchroniser
      cyc(3);
      rd(A1, 8'h00, OK, 1'b0);
      special_mode <= 1'b0;
      $display("reset test done");
   endtask
   task automatic t_power;
      wr(A3, 8'h02);
      wr(A2, 8'h80);
      cyc(2);
      `CHK(powered, 1'b1)
      rd(A3, 8'h02);
      wr(A5, 8'h00);
      cyc(2);
      `CHK(converting, 1'b1)
      wr(A2, 8'h00);
      cyc(2);
      `CHK(powered, 1'b0)
      `CHK(converting, 1'b0)
      $display("power test done");
   endtask
   task automatic t_stop;
      wr(A2, 8'h80);
      wr(A5, 8'h00);
      stop_req <= 1'b1;
      cyc(5);
      `CHK(powered, 1'b0)
      `CHK(converting, 1'b0)
      stop_req <= 1'b0;
      cyc(5);
      `CHK(powered, 1'b1)
      $display("stop test done");
   endtask
   task automatic t_wait;
      wait_req <= 1'b1;
      cyc(5);
      `CHK(powered, 1'b1)
      wait_req <= 1'b0;
      wr(A2, 8'ha0);
      wr(A5, 8'h00);
      wait_req <= 1'b1;
      cyc(5);
      `CHK(powered, 1'b0)
      rd(A2, 8'h00, SE);
      wait_req <= 1'b0;
      cyc(5);
      `CHK(powered, 1'b1)
      `CHK(converting, 1'b1)
      rd(A2, 8'ha0);
      $display("wait test done");
   endtask
   task automatic t_freeze;
      wr(A2, 8'h80);
      for (int f = 0; f < 4; f++) begin
         wr(A3, f[7:0]);
         wr(A5, 8'h00);
         debug_freeze_signal <= 1'b1;
         cyc(40);
         `CHK(frozen, 1'(f != 0))
         rd(A3, f[7:0]);
         debug_freeze_signal <= 1'b0;
         cyc(5);
         `CHK(frozen, 1'b0)
         if (f == 1) `CHK(converting, 1'b0)
         rd(A2, 8'h80);
      end
      $display("freeze test done");
   endtask
   task automatic t_soft_reset;
      wr(A3, 8'h02);
      wr(A5, 8'h00);
      wr(AT, 8'h01);
      cyc(3);
      `CHK(powered, 1'b1)
      `CHK(converting, 1'b0)
      rd(A3, 8'h00);
      rd(AT, 8'h00);
      rd(AS, 8'h00);
      rd(A2, 8'h80);
      $display("soft reset test done");
   endtask
   task automatic t_abort;
      wr(A5, 8'h00);
      wr(A2, 8'h81);
      wr(A3, 8'h00);
      `CHK(converting, 1'b1)
      rd(A2, 8'h80);
      wr(A0, 8'h00);
      cyc(2);
      `CHK(converting, 1'b0)
      rd(A0, 8'h00);
      wr(A4, 8'h00);
      cyc(2);
      `CHK(converting, 1'b1)
      // first conversion done, second still running
      cyc(20);
      rd(AS, 8'h01);
      wr(A5, 8'h00);
      rd(AS, 8'h00);
      $display("abort test done");
   endtask
   task automatic t_port;
      analog_pin_digital_port <= 8'ha5;
      wr(A5, 8'h00);
      cyc(3);
      rd(AP, 8'ha5);
      `CHK(converting, 1'b1)
      $display("port test done");
   endtask

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("FAIL %0t timeout", $time);
         finish_test();
      end
   end

   initial begin
      {rst_b, stop_req, wait_req, debug_freeze_signal, special_mode} = 5'h00;
      analog_pin_digital_port = 8'h3c;
      cyc(20);
      rst_b <= 1'b1;
      cyc(1);
      t_reset();
      t_power();
      t_stop();
      t_wait();
      t_freeze();
      t_soft_reset();
      t_abort();
      t_port();
      finish_test();
   end
endmodule // adc_power_freeze_reset_control_tb
